// [hw/fild_top.v]
// Four-channel fault input level detector with APB registers and interrupt.
`timescale 1ns/1ps
`include "fild_defs.vh"
module fild_top #(
    parameter LEGACY = 0
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        fault_in_a_n,
    input  wire        fault_in_b_n,
    input  wire        fault_in_c_n,
    input  wire        fault_in_d_n,
    output wire        request_flag_a,
    output wire        request_flag_b,
    output wire        request_flag_c,
    output wire        request_flag_d,
    output wire        output_disable_req,
    output wire        irq
);
    localparam NCH = 4;

    wire [NCH-1:0] pins_n;
    wire [NCH-1:0] flags;
    wire [NCH-1:0] detect;
    wire [NCH-1:0] lvl_mode;
    wire [NCH-1:0] chan_hit;
    wire [NCH-1:0] chan_wr;
    wire [NCH-1:0] chan_rd_one;
    reg  [NCH-1:0] flags_q;
    reg  [3:0]     detect_mode_a;
    reg  [3:0]     detect_mode_b;
    reg  [3:0]     detect_mode_c;
    reg  [3:0]     detect_mode_d;
    reg  [3:0]     sample_count_a;
    reg  [3:0]     sample_count_b;
    reg  [3:0]     sample_count_c;
    reg  [3:0]     sample_count_d;
    reg  [NCH-1:0] int_stat;
    reg  [NCH-1:0] int_mask;
    reg  [31:0]    next_prdata;
    reg            next_err;
    reg            err_q;
    wire [15:0]    mode_bus;
    wire [15:0]    cnt_bus;
    wire           setup;
    wire           access;
    wire           wr_acc;
    wire           rd_acc;
    wire           is_stat;
    wire           is_mask;
    wire           is_pin;
    wire           mapped;
    wire           rise_any;
    wire [NCH-1:0] rise;
    wire           legacy_sel;

    // Gather pins, modes and counts into channel-indexed vectors.
    assign pins_n = {fault_in_d_n, fault_in_c_n, fault_in_b_n,
                     fault_in_a_n};
    assign mode_bus = {detect_mode_d, detect_mode_c, detect_mode_b,
                       detect_mode_a};
    assign cnt_bus = {sample_count_d, sample_count_c, sample_count_b,
                      sample_count_a};
    assign legacy_sel = (LEGACY != 0);

    // APB phase decode.
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_acc = access && pwrite;
    assign rd_acc = access && !pwrite;

    // Address decode for the shared registers.
    assign is_stat = (paddr == `FILD_OFF_INT_STAT);
    assign is_mask = (paddr == `FILD_OFF_INT_MASK);
    assign is_pin = (paddr == `FILD_OFF_PIN_STAT);
    assign mapped = (|chan_hit) || is_stat || is_mask || is_pin;

    // Channel register hits by offset.
    assign chan_hit[0] = (paddr == `FILD_OFF_CHAN_A);
    assign chan_hit[1] = (paddr == `FILD_OFF_CHAN_B);
    assign chan_hit[2] = (paddr == `FILD_OFF_CHAN_C);
    assign chan_hit[3] = (paddr == `FILD_OFF_CHAN_D);

    // The slave answers in the first access cycle.
    assign pready = 1'b1;
    assign pslverr = access && err_q;

    // One sampler and one flag per channel.
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
            // Flag byte must be enabled for the write to reach the flag.
            assign chan_wr[ch] = wr_acc && chan_hit[ch] && pstrb[1];
            // The read arms clearing only if it returned a one.
            assign chan_rd_one[ch] = rd_acc && chan_hit[ch] &&
                                     prdata[`FILD_FLAG_BIT];

            fild_sampler u_sampler (
                .core_clk   (core_clk),
                .rst_n      (rst_n),
                .pin_n      (pins_n[ch]),
                .mode       (mode_bus[ch*4 +: 4]),
                .count_sel  (cnt_bus[ch*4 +: 4]),
                .legacy     (legacy_sel),
                .level_mode (lvl_mode[ch]),
                .detect     (detect[ch])
            );

            fild_flag u_flag (
                .core_clk   (core_clk),
                .rst_n      (rst_n),
                .set        (detect[ch]),
                .rd_one     (chan_rd_one[ch]),
                .wr         (chan_wr[ch]),
                .wr_bit     (pwdata[`FILD_FLAG_BIT]),
                .level_mode (lvl_mode[ch]),
                .pin_high   (pins_n[ch]),
                .flag       (flags[ch])
            );
        end
    endgenerate

    // Flag outputs and the disable request to the output stage.
    assign request_flag_a = flags[0];
    assign request_flag_b = flags[1];
    assign request_flag_c = flags[2];
    assign request_flag_d = flags[3];
    assign output_disable_req = |flags;

    // Interrupt events are flag rises.
    assign rise = flags & ~flags_q;
    assign rise_any = |rise;
    assign irq = |(int_stat & int_mask);

    // Mode and count fields, written through byte lane zero.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            detect_mode_a <= `FILD_MODE_RST;
            detect_mode_b <= `FILD_MODE_RST;
            detect_mode_c <= `FILD_MODE_RST;
            detect_mode_d <= `FILD_MODE_RST;
            sample_count_a <= `FILD_CNT_RST;
            sample_count_b <= `FILD_CNT_RST;
            sample_count_c <= `FILD_CNT_RST;
            sample_count_d <= `FILD_CNT_RST;
        end else if (wr_acc && pstrb[0]) begin
            // Software keeps mode codes within the defined set.
            if (chan_hit[0]) begin
                detect_mode_a <= pwdata[`FILD_MODE_MSB:`FILD_MODE_LSB];
                sample_count_a <= pwdata[`FILD_CNT_MSB:`FILD_CNT_LSB];
            end
            if (chan_hit[1]) begin
                detect_mode_b <= pwdata[`FILD_MODE_MSB:`FILD_MODE_LSB];
                sample_count_b <= pwdata[`FILD_CNT_MSB:`FILD_CNT_LSB];
            end
            if (chan_hit[2]) begin
                detect_mode_c <= pwdata[`FILD_MODE_MSB:`FILD_MODE_LSB];
                sample_count_c <= pwdata[`FILD_CNT_MSB:`FILD_CNT_LSB];
            end
            if (chan_hit[3]) begin
                detect_mode_d <= pwdata[`FILD_MODE_MSB:`FILD_MODE_LSB];
                sample_count_d <= pwdata[`FILD_CNT_MSB:`FILD_CNT_LSB];
            end
        end
    end

    // Sticky interrupt status with write-one-to-clear; set wins.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat <= 4'h0;
            flags_q <= 4'h0;
        end else begin
            flags_q <= flags;
            if (wr_acc && is_stat && pstrb[0])
                int_stat <= rise | (int_stat & ~pwdata[3:0]);
            else if (rise_any)
                int_stat <= int_stat | rise;
        end
    end

    // Interrupt mask register.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            int_mask <= `FILD_MASK_RST;
        else if (wr_acc && is_mask && pstrb[0])
            int_mask <= pwdata[3:0];
    end

    // Read mux, evaluated for the setup cycle's address.
    always @* begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        case (1'b1)
            chan_hit[0]: begin
                next_prdata[`FILD_MODE_MSB:`FILD_MODE_LSB] = detect_mode_a;
                next_prdata[`FILD_CNT_MSB:`FILD_CNT_LSB] = sample_count_a;
                next_prdata[`FILD_FLAG_BIT] = flags[0];
            end
            chan_hit[1]: begin
                next_prdata[`FILD_MODE_MSB:`FILD_MODE_LSB] = detect_mode_b;
                next_prdata[`FILD_CNT_MSB:`FILD_CNT_LSB] = sample_count_b;
                next_prdata[`FILD_FLAG_BIT] = flags[1];
            end
            chan_hit[2]: begin
                next_prdata[`FILD_MODE_MSB:`FILD_MODE_LSB] = detect_mode_c;
                next_prdata[`FILD_CNT_MSB:`FILD_CNT_LSB] = sample_count_c;
                next_prdata[`FILD_FLAG_BIT] = flags[2];
            end
            chan_hit[3]: begin
                next_prdata[`FILD_MODE_MSB:`FILD_MODE_LSB] = detect_mode_d;
                next_prdata[`FILD_CNT_MSB:`FILD_CNT_LSB] = sample_count_d;
                next_prdata[`FILD_FLAG_BIT] = flags[3];
            end
            is_stat: next_prdata[3:0] = int_stat;
            is_mask: next_prdata[3:0] = int_mask;
            is_pin:  next_prdata[3:0] = pins_n;
            default: next_err = 1'b1; // Unmapped: zero data, error.
        endcase
    end

    // Read data and error are captured in the setup cycle.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : next_prdata;
            err_q <= next_err || !mapped;
        end
    end
endmodule // fild_top

// [shared/fild_defs.vh]
// Constants for the fault input level detector: offsets, fields, codes, counts.
`ifndef FILD_DEFS_VH
`define FILD_DEFS_VH

// Register byte offsets.
`define FILD_OFF_CHAN_A    8'h00
`define FILD_OFF_CHAN_B    8'h04
`define FILD_OFF_CHAN_C    8'h08
`define FILD_OFF_CHAN_D    8'h0c
`define FILD_OFF_INT_STAT  8'h10
`define FILD_OFF_INT_MASK  8'h14
`define FILD_OFF_PIN_STAT  8'h18

// Field positions inside a channel register.
`define FILD_MODE_LSB      0
`define FILD_MODE_MSB      3
`define FILD_CNT_LSB       4
`define FILD_CNT_MSB       7
`define FILD_FLAG_BIT      12

// Reset values.
`define FILD_MODE_RST      4'h0
`define FILD_CNT_RST       4'h0
`define FILD_MASK_RST      4'h0

// Detection mode codes.
`define FILD_MODE_EDGE     4'h0
`define FILD_MODE_DIV8     4'h1
`define FILD_MODE_DIV16    4'h2
`define FILD_MODE_DIV128   4'h3
`define FILD_MODE_DIV1     4'h4
`define FILD_MODE_DIV2     4'h5
`define FILD_MODE_DIV4     4'h6

// Legacy two-bit mode codes.
`define FILD_LMODE_EDGE    2'h0
`define FILD_LMODE_DIV8    2'h1
`define FILD_LMODE_DIV16   2'h2
`define FILD_LMODE_DIV128  2'h3

// Sampling divisors in clock cycles and the fixed legacy count.
`define FILD_DIV_1         8'h01
`define FILD_DIV_2         8'h02
`define FILD_DIV_4         8'h04
`define FILD_DIV_8         8'h08
`define FILD_DIV_16        8'h10
`define FILD_DIV_128       8'h80
`define FILD_LEGACY_COUNT  5'h10

`endif

// [hw/fild_sampler.v]
// Per-channel pin sampler: prescaler, consecutive-low counter, edge detect.
`timescale 1ns/1ps
`include "fild_defs.vh"
module fild_sampler (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       pin_n,
    input  wire [3:0] mode,
    input  wire [3:0] count_sel,
    input  wire       legacy,
    output wire       level_mode,
    output wire       detect
);
    reg  [7:0] div;
    reg        lvl;
    reg        edg;
    reg  [7:0] pre_cnt;
    reg  [4:0] low_cnt;
    reg        pin_prev;
    reg  [7:0] cfg_q;
    wire       cfg_chg;
    wire [4:0] need;
    wire       tick;
    wire [4:0] low_inc;

    // Decode the mode into a divisor and a detection style.
    always @* begin
        div = `FILD_DIV_1;
        lvl = 1'b0;
        edg = 1'b0;
        if (legacy) begin
            case (mode[1:0])
                `FILD_LMODE_EDGE: edg = 1'b1;
                `FILD_LMODE_DIV8: begin
                    div = `FILD_DIV_8;
                    lvl = 1'b1;
                end
                `FILD_LMODE_DIV16: begin
                    div = `FILD_DIV_16;
                    lvl = 1'b1;
                end
                default: begin
                    div = `FILD_DIV_128;
                    lvl = 1'b1;
                end
            endcase
        end else begin
            case (mode)
                `FILD_MODE_EDGE: edg = 1'b1;
                `FILD_MODE_DIV8: begin
                    div = `FILD_DIV_8;
                    lvl = 1'b1;
                end
                `FILD_MODE_DIV16: begin
                    div = `FILD_DIV_16;
                    lvl = 1'b1;
                end
                `FILD_MODE_DIV128: begin
                    div = `FILD_DIV_128;
                    lvl = 1'b1;
                end
                `FILD_MODE_DIV1: begin
                    div = `FILD_DIV_1;
                    lvl = 1'b1;
                end
                `FILD_MODE_DIV2: begin
                    div = `FILD_DIV_2;
                    lvl = 1'b1;
                end
                `FILD_MODE_DIV4: begin
                    div = `FILD_DIV_4;
                    lvl = 1'b1;
                end
                default: begin
                    div = `FILD_DIV_1; // Forbidden codes detect nothing.
                    lvl = 1'b0;
                end
            endcase
        end
    end

    // Required run length: field plus one, or sixteen in legacy.
    assign need = legacy ? `FILD_LEGACY_COUNT :
                  ({1'b0, count_sel} + 5'h01);
    // A new mode or count restarts the prescaler phase and the low run,
    // so a stale phase or a run counted under old settings never leaks.
    assign cfg_chg = ({mode, count_sel} != cfg_q);
    assign tick = lvl && !cfg_chg && (pre_cnt == (div - 8'h01));
    assign low_inc = low_cnt + 5'h01;
    assign level_mode = lvl;
    assign detect = (edg && pin_prev && !pin_n) ||
                    (tick && !pin_n && (low_inc == need));

    // Prescaler phase, low-run counter and previous pin level.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 8'h00;
            low_cnt <= 5'h00;
            pin_prev <= 1'b1;
            cfg_q <= 8'h00;
        end else begin
            pin_prev <= pin_n;
            cfg_q <= {mode, count_sel};
            if (!lvl || cfg_chg) begin
                pre_cnt <= 8'h00;
                low_cnt <= 5'h00;
            end else if (tick) begin
                pre_cnt <= 8'h00;
                if (pin_n)
                    low_cnt <= 5'h00;
                else if (low_cnt != need)
                    low_cnt <= low_inc; // Saturates so one run sets once.
            end else begin
                pre_cnt <= pre_cnt + 8'h01;
            end
        end
    end
endmodule // fild_sampler

// [hw/fild_flag.v]
// Request flag with read-one-then-write-zero clearing.
`timescale 1ns/1ps
module fild_flag (
    input  wire core_clk,
    input  wire rst_n,
    input  wire set,
    input  wire rd_one,
    input  wire wr,
    input  wire wr_bit,
    input  wire level_mode,
    input  wire pin_high,
    output reg  flag
);
    reg  armed;
    wire clear;

    // A zero write clears only when armed and, in level modes, pin high.
    assign clear = wr && !wr_bit && armed &&
                   (!level_mode || pin_high);

    // Set wins over clear; writing one never sets.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
            armed <= 1'b0;
        end else begin
            flag <= set | (flag & ~clear);
            if (wr)
                armed <= 1'b0;
            else if (rd_one)
                armed <= 1'b1;
        end
    end
endmodule // fild_flag

// [verif/fild_fault_src.sv]
// Behavioural source that drives the four active-low fault pins.
`timescale 1ns/1ps
module fild_fault_src (
    input  wire       core_clk,
    input  wire [3:0] level,
    output reg  [3:0] pin_n
);
    initial pin_n = 4'hf;

    // Pins follow the commanded level one clock later and idle high.
    always @(posedge core_clk) begin
        pin_n <= level;
    end
endmodule // fild_fault_src

// [verif/fild_assertions.sv]
// Concurrent checks on the detector's bus, pin and flag ports.
`timescale 1ns/1ps
`include "fild_defs.vh"
module fild_assertions (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fault_in_a_n,
    input wire logic        fault_in_b_n,
    input wire logic        fault_in_c_n,
    input wire logic        fault_in_d_n,
    input wire logic        request_flag_a,
    input wire logic        request_flag_b,
    input wire logic        request_flag_c,
    input wire logic        request_flag_d,
    input wire logic        output_disable_req,
    input wire logic        irq
);
    logic armed_a;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Remembers that the last access to channel a read a set flag.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_a <= 1'b0;
        end else if (psel && penable && paddr == `FILD_OFF_CHAN_A
                     && (!pwrite || pstrb[1])) begin
            armed_a <= !pwrite && prdata[`FILD_FLAG_BIT];
        end
    end

    sequence s_access;
        psel && penable && pready;
    endsequence

    sequence s_wr_a(bitv);
        s_access ##0 pwrite && pstrb[1] && paddr == `FILD_OFF_CHAN_A
            && pwdata[`FILD_FLAG_BIT] == bitv;
    endsequence

    a_disable_from_flags: assert property (
        output_disable_req == (request_flag_a || request_flag_b
            || request_flag_c || request_flag_d))
        else $error("disable request differs from flags");
    a_set_a_low: assert property (
        $rose(request_flag_a) |-> !$past(fault_in_a_n))
        else $error("flag a set without low pin");
    a_set_c_low: assert property (
        $rose(request_flag_c) |-> !$past(fault_in_c_n))
        else $error("flag c set without low pin");
    a_keep_unarmed: assert property (
        s_wr_a(1'b0) ##0 request_flag_a && !armed_a |=> request_flag_a)
        else $error("flag a cleared without read of one");
    a_clear_armed: assert property (
        s_wr_a(1'b0) ##0 armed_a && fault_in_a_n |=> !request_flag_a)
        else $error("armed zero write left flag a set");
    a_one_no_set: assert property (
        s_wr_a(1'b1) ##0 !request_flag_a && fault_in_a_n
            |=> !request_flag_a)
        else $error("writing one set flag a");
    a_unmapped_err: assert property (
        psel && penable && paddr > `FILD_OFF_PIN_STAT |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (
        psel && penable && paddr <= `FILD_OFF_PIN_STAT
            && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access flagged as error");
    a_rdata_held: assert property (
        s_access ##1 !psel |-> $stable(prdata))
        else $error("read data changed after access");
endmodule // fild_assertions

bind fild_top fild_assertions i_fild_assertions (
    .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_in_a_n(fault_in_a_n),
    .fault_in_b_n(fault_in_b_n), .fault_in_c_n(fault_in_c_n),
    .fault_in_d_n(fault_in_d_n), .request_flag_a(request_flag_a),
    .request_flag_b(request_flag_b), .request_flag_c(request_flag_c),
    .request_flag_d(request_flag_d), .irq(irq),
    .output_disable_req(output_disable_req));

// [verif/fild_top_tb_top.sv]
// Self-checking testbench for the fault input level detector.
`timescale 1ns/1ps
`include "fild_defs.vh"
module fild_top_tb_top;
    reg         core_clk, rst_n, psel, penable, pwrite, e;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, r;
    reg  [3:0]  pstrb, lvl;
    wire [31:0] prdata;
    wire        pready, pslverr, odr, irq;
    wire [3:0]  pins, flags;
    wire [3:0]  lflags;
    wire [7:0]  all_flags;
    integer     fail_count, comparisons, i, k, cyc, dv;

    fild_top #(.LEGACY(0)) i_fild_top (
        .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_in_a_n(pins[0]),
        .fault_in_b_n(pins[1]), .fault_in_c_n(pins[2]),
        .fault_in_d_n(pins[3]), .request_flag_a(flags[0]),
        .request_flag_b(flags[1]), .request_flag_c(flags[2]),
        .request_flag_d(flags[3]), .output_disable_req(odr), .irq(irq));
    fild_fault_src i_fild_fault_src (
        .core_clk(core_clk), .level(lvl), .pin_n(pins));

    // Legacy copy on the same bus and pins; only its flags are watched.
    fild_top #(.LEGACY(1)) i_fild_top_legacy (
        .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
        .fault_in_a_n(pins[0]), .fault_in_b_n(pins[1]),
        .fault_in_c_n(pins[2]), .fault_in_d_n(pins[3]),
        .request_flag_a(lflags[0]), .request_flag_b(lflags[1]),
        .request_flag_c(lflags[2]), .request_flag_d(lflags[3]),
        .output_disable_req(), .irq());
    assign all_flags = {lflags, flags};

    // Free-running core clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task check(input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // One APB transfer; read data and error land in r and e.
    task apb(input [7:0] a, input w, input [31:0] d);
        integer n;
        begin
            @(posedge core_clk);
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            psel <= 1'b1;
            @(posedge core_clk);
            penable <= 1'b1;
            n = 0;
            @(posedge core_clk);
            while (pready !== 1'b1 && n < 20) begin
                @(posedge core_clk);
                n = n + 1;
            end
            if (n >= 20) begin
                fail_count = fail_count + 1;
                stop_test;
            end
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            #1;
        end
    endtask

    // Counts cycles until a channel flag rises, within a limit.
    task wait_flag(input integer ch, input integer lim);
        begin
            cyc = 0;
            while (all_flags[ch] !== 1'b1 && cyc < lim) begin
                @(posedge core_clk);
                #1;
                cyc = cyc + 1;
            end
            if (all_flags[ch] !== 1'b1) begin
                fail_count = fail_count + 1;
                stop_test;
            end
        end
    endtask

    // Main sequence of tests.
    initial begin
        fail_count = 0;
        comparisons = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        lvl = 4'hf;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 7; i = i + 1) begin
            apb(4 * i, 1'b0, 32'h0);
            check(r, (i == 6) ? 32'hf : 32'h0);
        end
        apb(8'h1c, 1'b0, 32'h0);
        check({e, r[30:0]}, 32'h80000000);
        $display("test reset and map done");
        for (i = 0; i < 4; i = i + 1) begin
            lvl[i] <= 1'b0;
            wait_flag(i, 10);
            check(flags, 1 << i);
            check(odr, 1);
            apb(`FILD_OFF_CHAN_A + 4 * i, 1'b1, 32'h0);
            check(flags[i], 1);
            lvl[i] <= 1'b1;
            apb(`FILD_OFF_CHAN_A + 4 * i, 1'b0, 32'h0);
            check(r[`FILD_FLAG_BIT], 1);
            apb(`FILD_OFF_CHAN_A + 4 * i, 1'b1, 32'h0);
            check(flags, 0);
            apb(`FILD_OFF_CHAN_A + 4 * i, 1'b1, 32'h1000);
            check(flags, 0);
        end
        $display("test edge mode done");
        apb(`FILD_OFF_INT_STAT, 1'b0, 32'h0);
        check(r, 32'hf);
        check(irq, 0);
        apb(`FILD_OFF_INT_MASK, 1'b1, 32'h1);
        check(irq, 1);
        apb(`FILD_OFF_INT_STAT, 1'b1, 32'h1);
        check(irq, 0);
        apb(`FILD_OFF_INT_STAT, 1'b0, 32'h0);
        check(r, 32'he);
        $display("test interrupt done");
        for (k = 1; k < 7; k = k + 1) begin
            // Sampling period of mode code k, needing k low samples.
            dv = (k == 3) ? 128 : (k < 3) ? (8 << (k - 1)) : (1 << (k - 4));
            apb(`FILD_OFF_CHAN_B, 1'b1, (k - 1) * 16 + k);
            lvl[1] <= 1'b0;
            wait_flag(1, 600);
            check(cyc >= k * dv, 1);
            check(cyc <= k * dv + 2, 1);
            // Clearing writes keep the level mode so the pin gate applies.
            apb(`FILD_OFF_CHAN_B, 1'b0, 32'h0);
            apb(`FILD_OFF_CHAN_B, 1'b1, (k - 1) * 16 + k);
            check(flags[1], 1);
            lvl[1] <= 1'b1;
            apb(`FILD_OFF_CHAN_B, 1'b0, 32'h0);
            apb(`FILD_OFF_CHAN_B, 1'b1, (k - 1) * 16 + k);
            check(flags[1], 0);
        end
        $display("test level modes done");
        apb(`FILD_OFF_CHAN_C, 1'b1, 32'h34);
        repeat (2) begin
            lvl[2] <= 1'b0;
            repeat (3) @(posedge core_clk);
            lvl[2] <= 1'b1;
            @(posedge core_clk);
        end
        repeat (5) @(posedge core_clk);
        #1;
        check(flags[2], 0);
        lvl[2] <= 1'b0;
        wait_flag(2, 20);
        check(cyc >= 3 && flags[2] === 1'b1, 1);
        $display("test restart done");
        // Legacy mode 01 needs sixteen lows taken every eighth clock.
        apb(`FILD_OFF_CHAN_D, 1'b1, 32'h1);
        lvl[3] <= 1'b0;
        wait_flag(7, 200);
        check(cyc >= 128 && cyc <= 130, 1);
        check(flags[3], 1);
        $display("test legacy done");
        stop_test;
    end
endmodule // fild_top_tb_top
